// ---- logic/pll_base_clock_select_regs.svh ----
// Register map, field positions, reset values and counts of the base clock block.
// Assumes an APB slave with byte addresses, one 32-bit word per register.
//
// Behaviour
// (R1) Zero reference divider or multiplier acts exactly like one.
// (R2) Zero range factor keeps PLL disabled and refuses the VCO clock.
// (R3) Source change passes transition control; base clock held static meanwhile.
// (R4) Transition control output divided by two gives the base clock.
// (R5) Base clock select bit in control register chooses the source.
// (R6) Select one drives halved prescaled VCO clock, zero halved oscillator.
// (R7) Selecting VCO clock ignored while PLL enable is clear.
// (R8) Clearing PLL enable ignored while VCO clock is selected.
// (R9) One write never changes both enable and select.
// (R10) Zero range factor forces oscillator as base clock source.
// (R11) PLL parameter fields writable only while PLL enable is zero.
// (R12) Parameters held as plain binary in their own registers.
// (R13) Base clock has 50 percent duty for either source.
// (R14) PLL reference clock is a buffered copy of oscillator clock.
// (R15) Interrupt request output derives from the lock detector.
// (R16) Lock-change flag requests interrupt only with lock interrupt enable.
// (R17) Lock toggle sets flag; any control register read clears it.
// (R18) VCO centre frequency is range times two-power times 125 kHz.
// (R19) Old clock stops on its falling edge before new one starts.
// (R20) Software programs parameters, enables, waits lock, then selects.
`ifndef PLL_BASE_CLOCK_SELECT_REGS_SVH
`define PLL_BASE_CLOCK_SELECT_REGS_SVH

`define OFF_CONTROL      8'h00
`define OFF_MUL_HIGH     8'h04
`define OFF_MUL_LOW      8'h08
`define OFF_VCO_RANGE    8'h0c
`define OFF_REF_DIVIDER  8'h10
`define OFF_STATUS       8'h14

`define CTRL_IRQEN_BIT   7
`define CTRL_EN_BIT      5
`define CTRL_SEL_BIT     4
`define CTRL_PRE_LSB     2
`define CTRL_POW2_LSB    0

`define RST_CONTROL      8'h20
`define RST_MULTIPLIER   12'h040
`define RST_VCO_RANGE    8'h40
`define RST_REF_DIVIDER  4'h1

`define NEW_CLOCK_EDGES  2'h2
`define FNOM_KHZ         18'h0007d

`endif

// ---- logic/pll_clk_pkg.sv ----
// Types shared by the base clock select block.
// Assumes the register header supplies all offsets and reset values.
`default_nettype none
package pll_clk_pkg;

	typedef struct packed {
		logic       lockIrqEnable;
		logic       lockChangeFlag;
		logic       pllEnable;
		logic       baseClockSelect;
		logic [1:0] prescaler;
		logic [1:0] vcoPow2Range;
	} pll_control_type;

	typedef struct packed {
		logic        pllActive;
		logic [1:0]  prescaler;
		logic [1:0]  vcoPow2Range;
		logic [11:0] multiplier;
		logic [7:0]  vcoRange;
		logic [3:0]  refDivider;
		logic [17:0] vcoCenterKhz;
	} pll_cfg_type;

	typedef enum logic [1:0] {
		SW_RUN,
		SW_STOP_OLD,
		SW_START_NEW
	} switch_state_type;

endpackage
`default_nettype wire

// ---- logic/sync_edge.sv ----
// Two-flop synchronisers with edge pulses for asynchronous clock and level inputs.
// Assumes inputs change slower than half the sampling clock rate.
`default_nettype none
module sync_edge #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Asynchronous side
	input  wire logic [WIDTH-1:0] asyncIn,
	// Synchronised side
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gen_bit
			logic [2:0] shift_reg;
			logic [2:0] shift_next;

			always_comb begin
				shift_next = {shift_reg[1:0], asyncIn[i]};
			end

			always_ff @(posedge clk) begin
				if (!reset_n) begin
					shift_reg <= 3'h0;
				end else begin
					shift_reg <= shift_next;
				end
			end

			// Stage 0 feeds only stage 1
			assign level[i] = shift_reg[1];
			assign rise[i]  = shift_reg[1] & ~shift_reg[2];
			assign fall[i]  = ~shift_reg[1] & shift_reg[2];
		end
	endgenerate

endmodule
`default_nettype wire

// ---- logic/pll_base_clock_select.sv ----
// Digital control of the clock generator: APB registers, parameter
// interlocks, glitch-free base clock switch with divide by two, lock interrupt.
// Assumes both source clocks run below a quarter of clk; they are sampled.
`include "pll_base_clock_select_regs.svh"
`default_nettype none
module pll_base_clock_select (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Source clocks and lock detector
	input  wire logic                     oscClock,
	input  wire logic                     prescaledVcoClock,
	input  wire logic                     lockIndicator,
	// Clock outputs
	output logic                          baseClockOut,
	output logic                          pllRefClock,
	// Interrupt and analog configuration
	output logic                          lockChangeIrq,
	output var pll_clk_pkg::pll_cfg_type  cfgOut
);
	import pll_clk_pkg::*;

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr == `OFF_CONTROL) || (addr == `OFF_MUL_HIGH) ||
			(addr == `OFF_MUL_LOW) || (addr == `OFF_VCO_RANGE) ||
			(addr == `OFF_REF_DIVIDER) || (addr == `OFF_STATUS);
	endfunction

	// Synchronised inputs: bit 0 oscillator, 1 VCO, 2 lock
	logic [2:0] syncLevel;
	logic [2:0] syncRise;
	logic [2:0] syncFall;

	sync_edge #(
		.WIDTH(3)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.asyncIn ({lockIndicator, prescaledVcoClock, oscClock}),
		.level   (syncLevel),
		.rise    (syncRise),
		.fall    (syncFall)
	);

	// APB handshake: one wait state, output data registered
	logic        ready_reg;
	logic        ready_next;
	logic        slvErr_reg;
	logic        slvErr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        access;
	logic        commit;
	logic        wrCtrl;
	logic        wrParam;
	logic        rdCtrl;
	logic [31:0] readData;

	// Register state
	pll_control_type ctrl_reg;
	pll_control_type ctrl_next;
	logic [11:0]     mul_reg;
	logic [11:0]     mul_next;
	logic [7:0]      range_reg;
	logic [7:0]      range_next;
	logic [3:0]      refDiv_reg;
	logic [3:0]      refDiv_next;
	logic            rangeZero;
	logic            lockToggle;
	logic            reqEnable;
	logic            reqSelect;
	logic            enableApplied;
	logic            selectAllowed;

	// Clock switch state
	switch_state_type state_reg;
	switch_state_type state_next;
	logic             activeSel_reg;
	logic             activeSel_next;
	logic             baseClk_reg;
	logic             baseClk_next;
	logic [1:0]       edgeCnt_reg;
	logic [1:0]       edgeCnt_next;
	logic             refClk_reg;
	logic             refClk_next;
	logic             irq_reg;
	logic             irq_next;
	logic             wantSel;
	logic             oldRise;
	logic             oldFall;
	logic             newRise;
	pll_cfg_type      cfg_reg;
	pll_cfg_type      cfg_next;

	assign access     = psel & penable;
	assign commit     = access & ready_reg;
	assign wrCtrl     = commit & pwrite & (paddr == `OFF_CONTROL);
	assign wrParam    = commit & pwrite & ~ctrl_reg.pllEnable; // R11
	assign rdCtrl     = commit & ~pwrite & (paddr == `OFF_CONTROL);
	assign rangeZero  = (range_reg == 8'h00);
	assign lockToggle = syncRise[2] | syncFall[2]; // R15

	always_comb begin
		readData = 32'h0000_0000;
		case (paddr)
			`OFF_CONTROL:     readData[7:0] = ctrl_reg;
			`OFF_MUL_HIGH:    readData[3:0] = mul_reg[11:8];
			`OFF_MUL_LOW:     readData[7:0] = mul_reg[7:0];
			`OFF_VCO_RANGE:   readData[7:0] = range_reg;
			`OFF_REF_DIVIDER: readData[3:0] = refDiv_reg;
			`OFF_STATUS:      readData[2:0] = {state_reg != SW_RUN, activeSel_reg, syncLevel[2]};
			default:          readData = 32'h0000_0000;
		endcase
	end

	always_comb begin
		ready_next  = access & ~ready_reg;
		slvErr_next = access & ~ready_reg & ~isMapped(paddr);
		rdata_next  = rdata_reg;
		if (access && !ready_reg && !pwrite) begin
			rdata_next = readData;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ready_reg  <= 1'b0;
			slvErr_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			ready_reg  <= ready_next;
			slvErr_reg <= slvErr_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Control register with enable/select interlocks
	always_comb begin
		ctrl_next     = ctrl_reg;
		reqEnable     = pwdata[`CTRL_EN_BIT];
		reqSelect     = pwdata[`CTRL_SEL_BIT];
		// Clearing enable refused while VCO is selected
		enableApplied = (ctrl_reg.baseClockSelect && !reqEnable) ? 1'b1 : reqEnable; // R8
		// Enable change in the same write blocks a select change
		selectAllowed = ctrl_reg.pllEnable && !rangeZero &&
			(enableApplied == ctrl_reg.pllEnable); // R7 R9 R2
		if (wrCtrl) begin
			ctrl_next.lockIrqEnable   = pwdata[`CTRL_IRQEN_BIT];
			ctrl_next.pllEnable       = enableApplied;
			ctrl_next.baseClockSelect = reqSelect ? (ctrl_reg.baseClockSelect | selectAllowed)
				: 1'b0; // R5
			if (!ctrl_reg.pllEnable) begin
				ctrl_next.prescaler    = pwdata[`CTRL_PRE_LSB +: 2]; // R11 R12
				ctrl_next.vcoPow2Range = pwdata[`CTRL_POW2_LSB +: 2]; // R11 R12
			end
		end
		// Toggle in the clearing cycle wins over the read
		if (lockToggle) begin
			ctrl_next.lockChangeFlag = 1'b1; // R17
		end else if (rdCtrl) begin
			ctrl_next.lockChangeFlag = 1'b0; // R17
		end
	end

	// Parameter registers, frozen while the PLL runs
	always_comb begin
		mul_next    = mul_reg;
		range_next  = range_reg;
		refDiv_next = refDiv_reg;
		if (wrParam && paddr == `OFF_MUL_HIGH) begin
			mul_next[11:8] = pwdata[3:0]; // R12
		end
		if (wrParam && paddr == `OFF_MUL_LOW) begin
			mul_next[7:0] = pwdata[7:0]; // R12
		end
		if (wrParam && paddr == `OFF_VCO_RANGE) begin
			range_next = pwdata[7:0]; // R12
		end
		if (wrParam && paddr == `OFF_REF_DIVIDER) begin
			refDiv_next = pwdata[3:0]; // R12
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg   <= `RST_CONTROL;
			mul_reg    <= `RST_MULTIPLIER;
			range_reg  <= `RST_VCO_RANGE;
			refDiv_reg <= `RST_REF_DIVIDER;
		end else begin
			ctrl_reg   <= ctrl_next;
			mul_reg    <= mul_next;
			range_reg  <= range_next;
			refDiv_reg <= refDiv_next;
		end
	end

	// Effective analog configuration
	always_comb begin
		cfg_next              = cfg_reg;
		cfg_next.pllActive    = ctrl_reg.pllEnable & ~rangeZero; // R2
		cfg_next.prescaler    = ctrl_reg.prescaler;
		cfg_next.vcoPow2Range = ctrl_reg.vcoPow2Range;
		cfg_next.multiplier   = (mul_reg == 12'h000) ? 12'h001 : mul_reg; // R1
		cfg_next.refDivider   = (refDiv_reg == 4'h0) ? 4'h1 : refDiv_reg; // R1
		cfg_next.vcoRange     = range_reg;
		cfg_next.vcoCenterKhz = 18'(({10'h000, range_reg} << ctrl_reg.vcoPow2Range)
			* `FNOM_KHZ); // R18
	end

	// Glitch-free switch; output frozen while any transition is pending
	assign wantSel = ctrl_reg.baseClockSelect & ctrl_reg.pllEnable & ~rangeZero; // R10 R6
	assign oldRise = activeSel_reg ? syncRise[1] : syncRise[0];
	assign oldFall = activeSel_reg ? syncFall[1] : syncFall[0];
	assign newRise = activeSel_reg ? syncRise[0] : syncRise[1];

	always_comb begin
		state_next     = state_reg;
		activeSel_next = activeSel_reg;
		baseClk_next   = baseClk_reg;
		edgeCnt_next   = edgeCnt_reg;
		case (state_reg)
			SW_RUN: begin
				if (wantSel != activeSel_reg) begin
					state_next = SW_STOP_OLD; // R3
				end else if (oldRise) begin
					// Toggle per source rise gives half rate, even duty
					baseClk_next = ~baseClk_reg; // R4 R13
				end
			end
			SW_STOP_OLD: begin
				if (oldFall) begin
					edgeCnt_next = 2'h0;
					state_next   = SW_START_NEW; // R19
				end
			end
			SW_START_NEW: begin
				if (newRise) begin
					if (edgeCnt_reg == `NEW_CLOCK_EDGES - 2'h1) begin
						activeSel_next = ~activeSel_reg; // R19
						edgeCnt_next   = 2'h0;
						state_next     = SW_RUN;
					end else begin
						edgeCnt_next = edgeCnt_reg + 2'h1;
					end
				end
			end
			default: begin
				state_next = SW_RUN;
			end
		endcase
		refClk_next = syncLevel[0]; // R14
		irq_next    = ctrl_reg.lockChangeFlag & ctrl_reg.lockIrqEnable; // R16
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg     <= SW_RUN;
			activeSel_reg <= 1'b0;
			baseClk_reg   <= 1'b0;
			edgeCnt_reg   <= 2'h0;
			refClk_reg    <= 1'b0;
			irq_reg       <= 1'b0;
			cfg_reg       <= '0;
		end else begin
			state_reg     <= state_next;
			activeSel_reg <= activeSel_next;
			baseClk_reg   <= baseClk_next;
			edgeCnt_reg   <= edgeCnt_next;
			refClk_reg    <= refClk_next;
			irq_reg       <= irq_next;
			cfg_reg       <= cfg_next;
		end
	end

	assign prdata        = rdata_reg;
	assign pready        = ready_reg;
	assign pslverr       = slvErr_reg;
	assign baseClockOut  = baseClk_reg;
	assign pllRefClock   = refClk_reg;
	assign lockChangeIrq = irq_reg;
	assign cfgOut        = cfg_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	zero_mul_a: assert property ((mul_reg == 12'h000) |=> (cfgOut.multiplier == 12'h001)) // R1
		else $error("zero multiplier not treated as one");
	zero_div_a: assert property ((refDiv_reg == 4'h0) |=> (cfgOut.refDivider == 4'h1)) // R1
		else $error("zero divider not treated as one");
	range_off_a: assert property (rangeZero |=> !cfgOut.pllActive) // R2
		else $error("pll active with zero range");
	stasis_hold_a: assert property ((state_reg != SW_RUN) |=> $stable(baseClockOut)) // R3
		else $error("base clock moved during transition");
	half_rate_a: assert property ($changed(baseClockOut) |-> $past(oldRise)) // R4
		else $error("base clock toggled without source rise");
	sel_refused_a: assert property ((wrCtrl && !ctrl_reg.pllEnable
		&& !ctrl_reg.baseClockSelect) |=> !ctrl_reg.baseClockSelect) // R7
		else $error("vco selected while pll off");
	off_refused_a: assert property ((wrCtrl && ctrl_reg.baseClockSelect)
		|=> ctrl_reg.pllEnable) // R8
		else $error("pll disabled while vco selected");
	single_change_a: assert property (wrCtrl |=> !($changed(ctrl_reg.pllEnable)
		&& $changed(ctrl_reg.baseClockSelect))) // R9
		else $error("enable and select changed together");
	osc_forced_a: assert property ((rangeZero && state_reg == SW_RUN
		&& !activeSel_reg) |=> !activeSel_reg) // R10
		else $error("vco taken with zero range");
	param_frozen_a: assert property (ctrl_reg.pllEnable |=> ($stable(mul_reg)
		&& $stable(range_reg) && $stable(refDiv_reg))) // R11
		else $error("parameter written while pll on");
	flag_set_a: assert property (lockToggle |=> ctrl_reg.lockChangeFlag) // R17
		else $error("lock toggle lost");
	irq_gate_a: assert property (lockChangeIrq |-> $past(ctrl_reg.lockChangeFlag
		&& ctrl_reg.lockIrqEnable)) // R16
		else $error("irq without enabled flag");
	ref_copy_a: assert property (##2 (pllRefClock == $past(syncLevel[0]))) // R14
		else $error("reference clock not a copy of oscillator");

	to_vco_c: cover property ((state_reg == SW_START_NEW) ##1 (state_reg == SW_RUN
		&& activeSel_reg));
	to_osc_c: cover property (activeSel_reg ##1 !activeSel_reg);
	flag_read_c: cover property (ctrl_reg.lockChangeFlag ##1 rdCtrl ##1
		!ctrl_reg.lockChangeFlag);
	refused_c: cover property (wrCtrl && pwdata[`CTRL_SEL_BIT] && !ctrl_reg.pllEnable);

endmodule
`default_nettype wire

// ---- verification/clock_partner_model.sv ----
// Far side of the base clock: source clocks, lock detector and a consumer
// that times each level of the base clock. Assumes one clk domain.
`default_nettype none
module clock_partner_model #(
	parameter int OSC_HALF = 8,
	parameter int VCO_HALF = 5
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Stimulus and observed clock
	input  wire logic lockLevel,
	input  wire logic baseClockOut,
	// Sources and measured level times
	output logic      oscClock,
	output logic      prescaledVcoClock,
	output logic      lockIndicator,
	output int        highTime,
	output int        lowTime
);
	timeunit 1ns;
	timeprecision 1ps;
	int   oscCnt;
	int   vcoCnt;
	int   run;
	logic lastBase;
	// Sources free-run from clk so level times come out exact
	always @(posedge clk) begin
		if (!reset_n) begin
			oscCnt <= 0;
			vcoCnt <= 0;
			run <= 0;
			lastBase <= 1'b0;
			oscClock <= 1'b0;
			prescaledVcoClock <= 1'b0;
			lockIndicator <= 1'b0;
			highTime <= 0;
			lowTime <= 0;
		end else begin
			oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
			vcoCnt <= (vcoCnt == VCO_HALF - 1) ? 0 : vcoCnt + 1;
			if (oscCnt == OSC_HALF - 1) oscClock <= ~oscClock;
			if (vcoCnt == VCO_HALF - 1) prescaledVcoClock <= ~prescaledVcoClock;
			lockIndicator <= lockLevel;
			lastBase <= baseClockOut;
			run <= (baseClockOut !== lastBase) ? 1 : run + 1;
			if (baseClockOut !== lastBase) begin
				if (lastBase) highTime <= run;
				else lowTime <= run;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb_pll_base_clock_select.sv ----
// Self-checking bench for the base clock block over APB.
// Assumes the partner model supplies source clocks and the lock level.
`default_nettype none
module tb_pll_base_clock_select;
	timeunit 1ns;
	timeprecision 1ps;
	import pll_clk_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic        oscClock, prescaledVcoClock, lockIndicator;
	logic        lockLevel = 1'b0;
	logic        baseClockOut, pllRefClock, lockChangeIrq;
	pll_cfg_type cfgOut;
	int          highTime, lowTime;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        err;

	pll_base_clock_select u_pll_base_clock_select (.clk(clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.oscClock(oscClock), .prescaledVcoClock(prescaledVcoClock),
		.lockIndicator(lockIndicator), .baseClockOut(baseClockOut),
		.pllRefClock(pllRefClock), .lockChangeIrq(lockChangeIrq), .cfgOut(cfgOut));
	clock_partner_model u_clock_partner_model (.clk(clk), .reset_n(reset_n),
		.lockLevel(lockLevel), .baseClockOut(baseClockOut), .oscClock(oscClock),
		.prescaledVcoClock(prescaledVcoClock), .lockIndicator(lockIndicator),
		.highTime(highTime), .lowTime(lowTime));

	always #12.5 clk = ~clk;

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard, well above the several hundred cycles the tests take
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			$display("Error timeout expected end seen hang");
			end_of_test();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Reads right after an edge see the values sampled at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("apb answer", 32'h1, {31'h0, n < 40});
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask

	task automatic wait_source(input logic vco);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h14, 32'h0);
			n++;
		end while (rd[1] !== vco && n < 30);
		check("active source", {31'h0, vco}, {31'h0, rd[1]});
	endtask

	// Each base level lasts one full source period; wait out the stasis level
	task automatic measure(input int half);
		repeat (10 * half) @(posedge clk);
		check("base high time", 2 * half, highTime);
		check("base low time", 2 * half, lowTime);
	endtask

	task automatic test_reset();
		rdchk("ctrl reset", 8'h00, 32'h20);
		rdchk("mul high reset", 8'h04, 32'h0);
		rdchk("mul low reset", 8'h08, 32'h40);
		rdchk("range reset", 8'h0c, 32'h40);
		rdchk("refdiv reset", 8'h10, 32'h1);
		check("mapped error", 32'h0, {31'h0, err});
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped read", 32'h0, rd);
		check("unmapped error", 32'h1, {31'h0, err});
		check("center khz", 32'h1f40, {14'h0, cfgOut.vcoCenterKhz});
	endtask

	task automatic test_params();
		apb(1'b1, 8'h08, 32'h55);
		rdchk("mul low locked", 8'h08, 32'h40);
		apb(1'b1, 8'h00, 32'h0f);
		rdchk("ctrl fields locked", 8'h00, 32'h00);
		apb(1'b1, 8'h00, 32'h02);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h10, 32'h0);
		repeat (2) @(posedge clk);
		check("mul zero", 32'h1, {20'h0, cfgOut.multiplier});
		check("refdiv zero", 32'h1, {28'h0, cfgOut.refDivider});
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, 8'h08, 32'hd1);
		apb(1'b1, 8'h10, 32'h1);
		repeat (2) @(posedge clk);
		check("multiplier", 32'h3d1, {20'h0, cfgOut.multiplier});
		rdchk("mul high", 8'h04, 32'h3);
	endtask

	task automatic test_range_zero();
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b1, 8'h00, 32'h22);
		apb(1'b1, 8'h00, 32'h32);
		rdchk("select refused", 8'h00, 32'h22);
		check("pll held off", 32'h0, {31'h0, cfgOut.pllActive});
		wait_source(1'b0);
		apb(1'b1, 8'h00, 32'h02);
		apb(1'b1, 8'h0c, 32'h40);
	endtask

	task automatic test_interlock();
		apb(1'b1, 8'h00, 32'h12);
		rdchk("select while off", 8'h00, 32'h02);
		apb(1'b1, 8'h00, 32'h32);
		rdchk("enable with select", 8'h00, 32'h22);
		repeat (2) @(posedge clk);
		check("center khz", 32'h7d00, {14'h0, cfgOut.vcoCenterKhz});
		check("pow2 range", 32'h2, {30'h0, cfgOut.vcoPow2Range});
		check("vco range", 32'h40, {24'h0, cfgOut.vcoRange});
	endtask

	task automatic test_switch();
		measure(8);
		apb(1'b1, 8'h00, 32'h32);
		wait_source(1'b1);
		measure(5);
		apb(1'b1, 8'h00, 32'h12);
		rdchk("disable while selected", 8'h00, 32'h32);
		apb(1'b1, 8'h00, 32'h22);
		wait_source(1'b0);
		measure(8);
		apb(1'b1, 8'h00, 32'h02);
	endtask

	task automatic test_lock();
		lockLevel <= 1'b1;
		repeat (8) @(posedge clk);
		check("irq masked", 32'h0, {31'h0, lockChangeIrq});
		rdchk("flag set", 8'h00, 32'h42);
		rdchk("flag cleared", 8'h00, 32'h02);
		apb(1'b1, 8'h00, 32'h82);
		lockLevel <= 1'b0;
		repeat (8) @(posedge clk);
		check("irq raised", 32'h1, {31'h0, lockChangeIrq});
		rdchk("flag and enable", 8'h00, 32'hc2);
		repeat (3) @(posedge clk);
		check("irq cleared", 32'h0, {31'h0, lockChangeIrq});
	endtask

	// Second reset in mid-run must restore every register
	task automatic test_mid_reset();
		reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		test_reset();
	endtask

	task automatic test_ref_clock();
		int t;
		logic last;
		t = 0;
		@(posedge clk);
		last = pllRefClock;
		repeat (160) begin
			@(posedge clk);
			if (pllRefClock !== last) t++;
			last = pllRefClock;
		end
		check("ref clock toggles", 32'd20, t);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		test_reset();
		test_params();
		test_range_zero();
		test_interlock();
		test_switch();
		test_lock();
		test_ref_clock();
		test_mid_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
